// ===== design/acqs_params.svh
`ifndef ACQS_PARAMS_SVH
`define ACQS_PARAMS_SVH
// register indices, byte address is four times the index
`define ACQS_IDX_CTR_CTL 6'h08
`define ACQS_IDX_STATUS 6'h09
`define ACQS_IDX_SESSION 6'h0a
`define ACQS_IDX_HIGH_PWR 6'h0e
`define ACQS_IDX_SETTINGS 6'h0f
// reset values and writable mask
`define ACQS_SETTINGS_RST 8'hff
`define ACQS_HIGH_PWR_RST 1'h0
`define ACQS_CTR_CTL_RST 16'h0000
`define ACQS_CTR_CTL_MASK 16'hfddb
// field positions
`define ACQS_F_COUPLING 3:0
`define ACQS_F_EXCITE 7:4
`define ACQS_F_HIGH_PWR 0
`define ACQS_F_SPD1_START 15:14
`define ACQS_F_GATE2_START 13:12
`define ACQS_F_GATE2_STOP 11:10
`define ACQS_F_GATE2_CLR 8
`define ACQS_F_SPD1_STOP 7:6
`define ACQS_F_SPD1_CLR 4
`define ACQS_F_SPD0_START 3
`define ACQS_F_SPD0_ZERO 1
`define ACQS_F_SPD0_STALE 0
`define ACQS_F_RESTORE 0
// bus answers
`define ACQS_RESP_OKAY 2'h0
`define ACQS_RESP_SLVERR 2'h2
`endif

// ===== design/acqs_pkg.sv
`default_nettype none
package acqs_pkg;
   // start and stop edge codes of the counters
   typedef enum logic [1:0] {
      ACQS_EDGE_READY_FALL = 2'h0,
      ACQS_EDGE_RESERVED = 2'h1,
      ACQS_EDGE_IN_FALL = 2'h2,
      ACQS_EDGE_IN_RISE = 2'h3
   } acqs_edge_type;
endpackage
`default_nettype wire

// ===== design/acqs_reg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface acqs_reg_if #(parameter int IDX_W = 6);
   logic wrEn;
   logic [IDX_W-1:0] wrIdx;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic wrHit;
   logic [IDX_W-1:0] rdIdx;
   logic [31:0] rdData;
   logic rdHit;
   // bus side issues accesses, register side answers
   modport bus (output wrEn, wrIdx, wrData, wrStrb, rdIdx,
      input wrHit, rdData, rdHit);
   modport regs (input wrEn, wrIdx, wrData, wrStrb, rdIdx,
      output wrHit, rdData, rdHit);
endinterface
`default_nettype wire

// ===== design/acqs_axil_slave.sv
`timescale 1ns/10ps
`default_nettype none
`include "acqs_params.svh"
module acqs_axil_slave #(
   parameter int ADDR_W = 8 // byte address width
) (
   input wire logic clk, // system clock
   input wire logic reset_n, // synchronous reset
   input wire logic [ADDR_W-1:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output var logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // byte lanes
   input wire logic wvalid, // write data valid
   output var logic wready, // write data ready
   output var logic [1:0] bresp, // write answer
   output var logic bvalid, // write answer valid
   input wire logic bready, // write answer taken
   input wire logic [ADDR_W-1:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output var logic arready, // read address ready
   output var logic [31:0] rdata, // read data
   output var logic [1:0] rresp, // read answer
   output var logic rvalid, // read data valid
   input wire logic rready, // read data taken
   acqs_reg_if.bus regBus // register access
);
   logic awReady_reg, wReady_reg, bValid_reg, arReady_reg, rValid_reg;
   logic [ADDR_W-3:0] wrIdx_reg;
   logic [31:0] wrData_reg, rData_reg;
   logic [3:0] wrStrb_reg;
   logic [1:0] bResp_reg, rResp_reg;
   wire awTake = awvalid & awReady_reg;
   wire wTake = wvalid & wReady_reg;
   wire bDone = bValid_reg & bready;
   wire arTake = arvalid & arReady_reg;
   wire rDone = rValid_reg & rready;
   // write fires once both halves are held, in either order
   assign regBus.wrEn = !awReady_reg && !wReady_reg && !bValid_reg;
   assign regBus.wrIdx = wrIdx_reg;
   assign regBus.wrData = wrData_reg;
   assign regBus.wrStrb = wrStrb_reg;
   assign regBus.rdIdx = araddr[ADDR_W-1:2];
   // write channels, each re-opened only after the answer
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         awReady_reg <= 1'b1;
         wReady_reg <= 1'b1;
         bValid_reg <= 1'b0;
         bResp_reg <= `ACQS_RESP_OKAY;
         wrIdx_reg <= '0;
         wrData_reg <= 32'h0;
         wrStrb_reg <= 4'h0;
      end else begin
         if (awTake) begin
            awReady_reg <= 1'b0;
            wrIdx_reg <= awaddr[ADDR_W-1:2];
         end else if (bDone) awReady_reg <= 1'b1;
         if (wTake) begin
            wReady_reg <= 1'b0;
            wrData_reg <= wdata;
            wrStrb_reg <= wstrb;
         end else if (bDone) wReady_reg <= 1'b1;
         if (regBus.wrEn) begin
            bValid_reg <= 1'b1;
            bResp_reg <= regBus.wrHit ? `ACQS_RESP_OKAY : `ACQS_RESP_SLVERR;
         end else if (bDone) bValid_reg <= 1'b0;
      end
   end
   // read data is captured in the address cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         arReady_reg <= 1'b1;
         rValid_reg <= 1'b0;
         rData_reg <= 32'h0;
         rResp_reg <= `ACQS_RESP_OKAY;
      end else if (arTake) begin
         arReady_reg <= 1'b0;
         rValid_reg <= 1'b1;
         rData_reg <= regBus.rdData;
         rResp_reg <= regBus.rdHit ? `ACQS_RESP_OKAY : `ACQS_RESP_SLVERR;
      end else if (rDone) begin
         arReady_reg <= 1'b1;
         rValid_reg <= 1'b0;
      end
   end
   assign awready = awReady_reg;
   assign wready = wReady_reg;
   assign bvalid = bValid_reg;
   assign bresp = bResp_reg;
   assign arready = arReady_reg;
   assign rvalid = rValid_reg;
   assign rdata = rData_reg;
   assign rresp = rResp_reg;
endmodule
`default_nettype wire

// ===== design/acqs_result_hold.sv
`timescale 1ns/10ps
`default_nettype none
module acqs_result_hold #(
   parameter int CNT_W = 32 // result width
) (
   input wire logic clk, // system clock
   input wire logic reset_n, // synchronous reset
   input wire logic [CNT_W-1:0] result, // finished measurement
   input wire logic done, // measurement complete pulse
   input wire logic xfer, // value written to input fifo
   input wire logic clearOnXfer, // zero the value after transfer
   input wire logic staleEn, // stale flag in use
   output var logic [CNT_W-1:0] value, // value returned
   output var logic stale // nothing new since last transfer
);
   logic [CNT_W-1:0] value_reg, value_next;
   logic fresh_reg, fresh_next, stale_reg;
   // a completion in the transfer cycle wins over the clear
   assign fresh_next = done | (fresh_reg & ~xfer);
   assign value_next = done ? result :
      (xfer && clearOnXfer) ? {CNT_W{1'b0}} : value_reg;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         value_reg <= {CNT_W{1'b0}};
         fresh_reg <= 1'b0;
         stale_reg <= 1'b0;
      end else begin
         value_reg <= value_next;
         fresh_reg <= fresh_next;
         stale_reg <= staleEn & ~fresh_next;
      end
   end
   assign value = value_reg;
   assign stale = stale_reg;
endmodule
`default_nettype wire

// ===== design/acqs_settings_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "acqs_params.svh"

// Behaviour
// - settings bits 3..0 pick DC (1) or AC (0) per channel, reset 1
// - settings bits 7..4 disable (1) excitation per channel, reset 1
// - words of 32 bits, only the low byte carries settings
// - high power keep-on: 1 keeps circuitry on, 0 off by default
// - only bit 0 of the high power location means anything
// - control 15:14 selects speed counter 1 start edge
// - control 7:6 selects speed counter 1 stop edge
// - control 13:12 selects gate counter 2 start edge
// - control 11:10 selects gate counter 2 stop edge
// - bits 8 and 4 choose hold or clear after fifo transfer
// - control bit 3 selects speed counter 0 start edge polarity
// - control bit 1 makes speed counter 0 return zeros between results
// - control bit 0 enables speed counter 0 stale flag
// - counter control returns to reset state when application exits
module acqs_settings_regs
   import acqs_pkg::*;
#(
   parameter int ADDR_W = 8, // byte address width
   parameter int CNT_W = 32 // counter result width
) (
   input wire logic clk, // 25 MHz system clock
   input wire logic reset_n, // synchronous reset
   input wire logic [ADDR_W-1:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output var logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // byte lanes
   input wire logic wvalid, // write data valid
   output var logic wready, // write data ready
   output var logic [1:0] bresp, // write answer
   output var logic bvalid, // write answer valid
   input wire logic bready, // write answer taken
   input wire logic [ADDR_W-1:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output var logic arready, // read address ready
   output var logic [31:0] rdata, // read data
   output var logic [1:0] rresp, // read answer
   output var logic rvalid, // read data valid
   input wire logic rready, // read data taken
   output var logic [3:0] couplingDc, // 1 = dc coupling
   output var logic [3:0] sensorExcitationOff, // 1 = source off
   output var logic highPowerOn, // keep high power on
   output var acqs_edge_type speed1StartSel, // speed 1 start edge
   output var acqs_edge_type speed1StopSel, // speed 1 stop edge
   output var acqs_edge_type gate2StartSel, // gate 2 start edge
   output var acqs_edge_type gate2StopSel, // gate 2 stop edge
   output var logic speed0StartFalling, // speed 0 falling start
   input wire logic [CNT_W-1:0] speed0Result, // speed 0 result
   input wire logic speed0Done, // speed 0 result ready
   input wire logic speed0Xfer, // speed 0 written to fifo
   output var logic [CNT_W-1:0] speed0Value, // speed 0 value
   output var logic speed0Stale, // speed 0 stale flag
   input wire logic [CNT_W-1:0] speed1Result, // speed 1 result
   input wire logic speed1Done, // speed 1 result ready
   input wire logic speed1Xfer, // speed 1 written to fifo
   output var logic [CNT_W-1:0] speed1Value, // speed 1 value
   input wire logic [CNT_W-1:0] gate2Result, // gate 2 result
   input wire logic gate2Done, // gate 2 result ready
   input wire logic gate2Xfer, // gate 2 written to fifo
   output var logic [CNT_W-1:0] gate2Value // gate 2 value
);
   localparam int IDX_W = ADDR_W - 2;

   logic [7:0] inputCouplingSourceByte_reg;
   logic [7:0] inputCouplingSourceByte_next;
   logic highPowerKeepOn_reg;
   logic highPowerKeepOn_next;
   logic [15:0] counterEdgeControl_reg;
   logic [15:0] counterEdgeControl_next;

   acqs_reg_if #(.IDX_W(IDX_W)) regBus ();

   // merge written byte lanes over the old word
   function automatic logic [31:0] laneMerge(
      input logic [31:0] oldWord,
      input logic [31:0] newWord,
      input logic [3:0] strb);
      logic [31:0] merged;
      merged = oldWord;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merged[8*i +: 8] = newWord[8*i +: 8];
         end
      end
      return merged;
   endfunction

   // an index answers only if a register lives there
   function automatic logic isMapped(input logic [IDX_W-1:0] idx);
      return idx == `ACQS_IDX_CTR_CTL || idx == `ACQS_IDX_STATUS ||
         idx == `ACQS_IDX_SESSION || idx == `ACQS_IDX_HIGH_PWR ||
         idx == `ACQS_IDX_SETTINGS;
   endfunction

   acqs_axil_slave #(.ADDR_W(ADDR_W)) busSlave (
      .clk(clk),
      .reset_n(reset_n),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .regBus(regBus.bus)
   );

   // write decode; all registers live in the low byte lanes
   wire lane0 = regBus.wrStrb[0];
   wire wrSettings = regBus.wrEn &&
      regBus.wrIdx == `ACQS_IDX_SETTINGS && lane0;
   wire wrHighPower = regBus.wrEn &&
      regBus.wrIdx == `ACQS_IDX_HIGH_PWR && lane0;
   wire wrCounterCtl = regBus.wrEn &&
      regBus.wrIdx == `ACQS_IDX_CTR_CTL;
   wire wrRestore = regBus.wrEn && regBus.wrIdx == `ACQS_IDX_SESSION &&
      lane0 && regBus.wrData[`ACQS_F_RESTORE];
   wire [31:0] ctlMerged = laneMerge({16'h0000, counterEdgeControl_reg},
      regBus.wrData, regBus.wrStrb);
   assign regBus.wrHit = isMapped(regBus.wrIdx);

   // upper 24 bits of the word are dropped on write
   assign inputCouplingSourceByte_next = wrSettings ?
      regBus.wrData[7:0] : inputCouplingSourceByte_reg;
   // only the low bit is kept, the rest need no masking
   assign highPowerKeepOn_next = wrHighPower ?
      regBus.wrData[`ACQS_F_HIGH_PWR] : highPowerKeepOn_reg;
   // unassigned control bits never store
   assign counterEdgeControl_next = wrRestore ? `ACQS_CTR_CTL_RST :
      wrCounterCtl ? (ctlMerged[15:0] & `ACQS_CTR_CTL_MASK) :
      counterEdgeControl_reg;

   // settings storage, defaults dc coupling and sources off
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         inputCouplingSourceByte_reg <= `ACQS_SETTINGS_RST;
         highPowerKeepOn_reg <= `ACQS_HIGH_PWR_RST;
      end else begin
         inputCouplingSourceByte_reg <= inputCouplingSourceByte_next;
         highPowerKeepOn_reg <= highPowerKeepOn_next;
      end
   end

   // counter control, cleared on reset and on application exit
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         counterEdgeControl_reg <= `ACQS_CTR_CTL_RST;
      end else begin
         counterEdgeControl_reg <= counterEdgeControl_next;
      end
   end

   // read decode; session reads zero, restore is a pulse
   wire [IDX_W-1:0] rIdx = regBus.rdIdx;
   assign regBus.rdHit = isMapped(rIdx);
   assign regBus.rdData =
      (rIdx == `ACQS_IDX_SETTINGS) ?
         {24'h000000, inputCouplingSourceByte_reg} :
      (rIdx == `ACQS_IDX_HIGH_PWR) ?
         {31'h00000000, highPowerKeepOn_reg} :
      (rIdx == `ACQS_IDX_CTR_CTL) ?
         {16'h0000, counterEdgeControl_reg} :
      (rIdx == `ACQS_IDX_STATUS) ?
         {31'h00000000, speed0Stale} : 32'h00000000;

   // configuration outputs straight from the stored bits
   assign couplingDc = inputCouplingSourceByte_reg[`ACQS_F_COUPLING];
   assign sensorExcitationOff =
      inputCouplingSourceByte_reg[`ACQS_F_EXCITE];
   assign highPowerOn = highPowerKeepOn_reg;
   // reserved code 01 is passed through as written
   assign speed1StartSel =
      acqs_edge_type'(counterEdgeControl_reg[`ACQS_F_SPD1_START]);
   assign speed1StopSel =
      acqs_edge_type'(counterEdgeControl_reg[`ACQS_F_SPD1_STOP]);
   assign gate2StartSel =
      acqs_edge_type'(counterEdgeControl_reg[`ACQS_F_GATE2_START]);
   assign gate2StopSel =
      acqs_edge_type'(counterEdgeControl_reg[`ACQS_F_GATE2_STOP]);
   assign speed0StartFalling =
      counterEdgeControl_reg[`ACQS_F_SPD0_START];

   // value returned between measurements, per counter
   wire spd0Zero = counterEdgeControl_reg[`ACQS_F_SPD0_ZERO];
   wire spd0StaleEn = counterEdgeControl_reg[`ACQS_F_SPD0_STALE];
   wire spd1Clear = counterEdgeControl_reg[`ACQS_F_SPD1_CLR];
   wire gate2Clear = counterEdgeControl_reg[`ACQS_F_GATE2_CLR];

   acqs_result_hold #(.CNT_W(CNT_W)) speed0Hold (
      .clk(clk),
      .reset_n(reset_n),
      .result(speed0Result),
      .done(speed0Done),
      .xfer(speed0Xfer),
      .clearOnXfer(spd0Zero),
      .staleEn(spd0StaleEn),
      .value(speed0Value),
      .stale(speed0Stale)
   );

   acqs_result_hold #(.CNT_W(CNT_W)) speed1Hold (
      .clk(clk),
      .reset_n(reset_n),
      .result(speed1Result),
      .done(speed1Done),
      .xfer(speed1Xfer),
      .clearOnXfer(spd1Clear),
      .staleEn(1'b0),
      .value(speed1Value),
      .stale()
   );

   acqs_result_hold #(.CNT_W(CNT_W)) gate2Hold (
      .clk(clk),
      .reset_n(reset_n),
      .result(gate2Result),
      .done(gate2Done),
      .xfer(gate2Xfer),
      .clearOnXfer(gate2Clear),
      .staleEn(1'b0),
      .value(gate2Value),
      .stale()
   );

   // checks on the stored state and the returned values
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence settingsWrite;
      regBus.wrEn && regBus.wrIdx == `ACQS_IDX_SETTINGS && lane0;
   endsequence

   sequence highPowerWrite;
      regBus.wrEn && regBus.wrIdx == `ACQS_IDX_HIGH_PWR && lane0;
   endsequence

   sequence fullCtlWrite;
      regBus.wrEn && regBus.wrIdx == `ACQS_IDX_CTR_CTL &&
         regBus.wrStrb[1:0] == 2'h3;
   endsequence

   sequence restoreWrite;
      wrRestore;
   endsequence

   sequence spd0XferOnly;
      speed0Xfer && !speed0Done;
   endsequence

   coupling_write_a: assert property (
      settingsWrite |=> couplingDc == $past(regBus.wrData[3:0]))
      else $error("coupling bits not taken from write");

   excite_write_a: assert property (
      settingsWrite |=> sensorExcitationOff == $past(regBus.wrData[7:4]))
      else $error("excitation bits not taken from write");

   low_byte_a: assert property (
      regBus.rdIdx == `ACQS_IDX_SETTINGS |->
         regBus.rdData[31:8] == 24'h000000 &&
         regBus.rdData[7:0] == {sensorExcitationOff, couplingDc})
      else $error("settings read not in low byte");

   high_power_a: assert property (
      highPowerWrite |=> highPowerOn == $past(regBus.wrData[0]))
      else $error("high power bit not taken from write");

   high_power_read_a: assert property (
      regBus.rdIdx == `ACQS_IDX_HIGH_PWR |->
         regBus.rdData == {31'h00000000, highPowerOn})
      else $error("high power read shows extra bits");

   edge_fields_a: assert property (
      fullCtlWrite |=>
         speed1StartSel == $past(regBus.wrData[15:14]) &&
         gate2StartSel == $past(regBus.wrData[13:12]) &&
         gate2StopSel == $past(regBus.wrData[11:10]) &&
         speed1StopSel == $past(regBus.wrData[7:6]) &&
         speed0StartFalling == $past(regBus.wrData[3]))
      else $error("edge select fields misplaced");

   reserved_zero_a: assert property (
      fullCtlWrite |=> regBus.wrEn ||
         (counterEdgeControl_reg[9] == 1'b0 &&
         counterEdgeControl_reg[5] == 1'b0 &&
         counterEdgeControl_reg[2] == 1'b0))
      else $error("unassigned control bit stored");

   exit_restore_a: assert property (
      restoreWrite |=> counterEdgeControl_reg == `ACQS_CTR_CTL_RST
         ##1 (counterEdgeControl_reg == `ACQS_CTR_CTL_RST || regBus.wrEn))
      else $error("control not restored on exit");

   zero_between_a: assert property (
      spd0XferOnly ##0 spd0Zero |=> speed0Value == {CNT_W{1'b0}})
      else $error("speed 0 not zeroed after transfer");

   hold_last_a: assert property (
      gate2Xfer && !gate2Done && !gate2Clear |=>
         gate2Value == $past(gate2Value))
      else $error("gate 2 value lost while holding");

   stale_mark_a: assert property (
      spd0XferOnly ##0 spd0StaleEn ##1 !speed0Done && spd0StaleEn
         |-> speed0Stale ##1 speed0Stale)
      else $error("stale flag missing after transfer");

   fresh_result_a: assert property (
      speed0Done |=> !speed0Stale && speed0Value == $past(speed0Result))
      else $error("fresh result marked stale");

   write_answer_a: assert property (
      regBus.wrEn |=> bvalid ##1 (bvalid || awready))
      else $error("write not answered");

endmodule
`default_nettype wire

// ===== verif/tb_acqs_settings_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_acqs_settings_regs;
   import acqs_pkg::*;
   // control register at index 8, byte address 0x20
   localparam logic [5:0] iCtl = 6'h08, iStat = 6'h09, iSess = 6'h0a;
   localparam logic [5:0] iPwr = 6'h0e, iSet = 6'h0f, iNone = 6'h00;
   logic clk, reset_n, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, highPowerOn;
   logic speed0StartFalling, speed0Stale;
   logic speed0Done, speed0Xfer, speed1Done, speed1Xfer, gate2Done, gate2Xfer;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, speed0Result, speed1Result, gate2Result;
   logic [31:0] speed0Value, speed1Value, gate2Value, d, b;
   logic [3:0] wstrb, couplingDc, sensorExcitationOff;
   logic [1:0] bresp, rresp, r;
   logic [15:0] v;
   acqs_edge_type speed1StartSel, speed1StopSel, gate2StartSel, gate2StopSel;
   int errTotal = 0;
   int samplesChecked = 0;

   acqs_settings_regs uut (.clk, .reset_n, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .couplingDc,
      .sensorExcitationOff, .highPowerOn, .speed1StartSel, .speed1StopSel,
      .gate2StartSel, .gate2StopSel, .speed0StartFalling, .speed0Result,
      .speed0Done, .speed0Xfer, .speed0Value, .speed0Stale, .speed1Result,
      .speed1Done, .speed1Xfer, .speed1Value, .gate2Result, .gate2Done,
      .gate2Xfer, .gate2Value);

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic final_report();
      $display("checks %0d errors %0d", samplesChecked, errTotal);
      if (errTotal == 0 && samplesChecked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errTotal++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // bounded wait step, a hung handshake ends the run
   task automatic tick(inout int n);
      @(posedge clk);
      n++;
      if (n > 100) begin
         errTotal++;
         final_report();
      end
   endtask

   // address and data offered together, each released when taken
   task automatic axiWrite(input logic [5:0] idx, input logic [31:0] dat,
         input logic [1:0] expResp);
      int n;
      logic aw, w;
      n = 0;
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk);
      awaddr <= {idx, 2'h0};
      wdata <= dat;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         tick(n);
         if (!aw && awready === 1'b1) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) tick(n);
      bready <= 1'b0;
      check({30'h0, bresp}, {30'h0, expResp});
   endtask

   task automatic axiRead(input logic [5:0] idx, output logic [31:0] dat,
         output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= {idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do tick(n); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) tick(n);
      dat = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   // the host never offers the reserved edge code
   function automatic logic [15:0] noRes(input logic [15:0] x);
      int p[4] = '{14, 12, 10, 6};
      for (int i = 0; i < 4; i++) begin
         if (x[p[i]+:2] == 2'h1) begin
            x[p[i]+1] = 1'b1;
         end
      end
      return x;
   endfunction

   // upper half and lanes 2..3 carry junk that must not stick
   task automatic ctlCheck(input logic [15:0] x);
      axiWrite(iCtl, {16'($urandom()), x}, 2'h0);
      axiRead(iCtl, d, r);
      check(d, {16'h0, x & 16'hfddb});
      check({16'h0, speed1StartSel, gate2StartSel, gate2StopSel, 2'h0,
         speed1StopSel, 2'h0, speed0StartFalling, 3'h0},
         {16'h0, x & 16'hfcc8});
   endtask

   initial begin
      {reset_n, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      {speed0Done, speed0Xfer, speed1Done, speed1Xfer} = '0;
      {gate2Done, gate2Xfer, speed0Result, speed1Result, gate2Result} = '0;
      void'($urandom(69));
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      axiRead(iSet, d, r);
      check(d, 32'hff);
      axiRead(iPwr, d, r);
      check(d, 32'h0);
      axiRead(iCtl, d, r);
      check(d, 32'h0);
      // unmapped place refuses both ways
      axiWrite(iNone, 32'hffffffff, 2'h2);
      axiRead(iNone, d, r);
      check({d[31:2], r}, 32'h2);
      for (int c = 0; c < 4; c++) begin
         if (c != 1) begin
            ctlCheck({{3{c[1:0]}}, 2'h0, c[1:0], 6'h3f});
         end
      end
      for (int i = 0; i < 6; i++) begin
         ctlCheck(noRes(16'($urandom())));
         b = $urandom();
         axiWrite(iSet, b, 2'h0);
         axiRead(iSet, d, r);
         check(d, {24'h0, b[7:0]});
         check({sensorExcitationOff, couplingDc}, {24'h0, b[7:0]});
         b = $urandom();
         axiWrite(iPwr, b, 2'h0);
         axiRead(iPwr, d, r);
         check(d, {31'h0, b[0]});
         check({31'h0, highPowerOn}, {31'h0, b[0]});
      end
      // single bit change by read, modify, write back
      axiRead(iSet, d, r);
      b = d ^ 32'h4;
      axiWrite(iSet, b, 2'h0);
      check({sensorExcitationOff, couplingDc}, b[7:0]);
      // application exit restores the control word
      ctlCheck(16'hffff);
      axiWrite(iSess, 32'h1, 2'h0);
      axiRead(iCtl, d, r);
      check(d, 32'h0);
      // counter groups: hold versus clear, stale flag off and on
      for (int m = 0; m < 2; m++) begin
         axiWrite(iCtl, (m == 1) ? 32'h0113 : 32'h0, 2'h0);
         @(posedge clk);
         speed0Result <= $urandom();
         speed1Result <= $urandom();
         gate2Result <= $urandom();
         {speed0Done, speed1Done, gate2Done} <= 3'h7;
         @(posedge clk);
         {speed0Done, speed1Done, gate2Done} <= 3'h0;
         @(negedge clk);
         check(speed0Value, speed0Result);
         check({31'h0, speed0Stale}, 32'h0);
         check(speed1Value, speed1Result);
         check(gate2Value, gate2Result);
         @(posedge clk);
         {speed0Xfer, speed1Xfer, gate2Xfer} <= 3'h7;
         @(posedge clk);
         {speed0Xfer, speed1Xfer, gate2Xfer} <= 3'h0;
         @(negedge clk);
         check(speed0Value, (m == 1) ? 32'h0 : speed0Result);
         check(speed1Value, (m == 1) ? 32'h0 : speed1Result);
         check(gate2Value, (m == 1) ? 32'h0 : gate2Result);
         axiRead(iStat, d, r);
         check(d, {31'h0, m[0]});
         check({31'h0, speed0Stale}, {31'h0, m[0]});
      end
      // leave the module warmed up, as the host is advised to
      axiWrite(iPwr, 32'h1, 2'h0);
      check({31'h0, highPowerOn}, 32'h1);
      final_report();
   end
endmodule
`default_nettype wire
